/* File: hw/crtp_pkg.sv */
// Shared types and constants of the capture record transmit path
package crtp_pkg;

    localparam int          DATA_W        = 64;
    localparam int          NPORT         = 4;
    localparam logic [31:0] TX_ALLOC_RST  = 32'h0100_0000;  // 16 MB
    localparam logic [31:0] TOTAL_MEM     = 32'h1000_0000;  // Buffer memory in bytes
    localparam logic [15:0] CRC_BYTES     = 16'h0004;
    localparam logic [15:0] WORD_BYTES    = 16'h0008;
    localparam logic [1:0]  BUF_DEPTH     = 2'h2;

    // Record header word, first word of every record
    typedef struct packed {
        logic [28:0] rsvd;
        logic        rx_err;
        logic [1:0]  port;
        logic [15:0] rec_words;   // Payload words after the header
        logic [15:0] frame_len;   // Frame bytes incl. CRC
    } crtp_hdr_t;

    // One beat towards the MAC
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [3:0]        nbytes;
        logic              sop;
        logic              eop;
        logic [1:0]        port;
        logic              append;
    } crtp_beat_t;

    typedef enum logic [1:0] {
        S_HDR  = 2'b00,
        S_LINK = 2'b01,
        S_BODY = 2'b10
    } crtp_state_t;

    typedef struct packed {
        crtp_state_t st;
        logic        drop;
        logic [1:0]  port;
        logic [15:0] words_left;
        logic [15:0] bytes_left;
        logic        sop;
        logic        append;
        logic [1:0]  cnt;
        crtp_beat_t  e0;
        crtp_beat_t  e1;
        logic        in_ready;
        logic [3:0]  urun;
        logic [31:0] tx_alloc;
        logic [31:0] rx_alloc;
        logic        busy;
        logic        out_valid;
    } crtp_regs_t;

endpackage

/* File: hw/crtp_tx_path.sv */
// Record-to-MAC transmit path with CRC strip, error drop and skid buffer
`timescale 1ns/1ps
// How it works
// - Transmit logic is independent; receive capture keeps running and its memory share.
// - Only beats taken from host records reach the MAC; nothing is generated.
// - Records flow back to back; timestamps are ignored, no gaps inserted.
// - With stripping on, the trailing four CRC bytes are not passed on.
// - With append on, the MAC is told to add a fresh CRC.
// - Strip off and append off sends original CRC bytes unaltered.
// - Drop-errored option discards records flagged as receive errors.
// - One record at a time, to one port, finished before the next.
// - After reset 16 MB goes to transmit, the rest to receive.
module crtp_tx_path (
    input  wire logic                       clk_i,           // 250 MHz clock
    input  wire logic                       rst_n_i,         // Async reset, active low
    input  wire logic [crtp_pkg::DATA_W-1:0] in_data_i,      // Record stream word
    input  wire logic                       in_valid_i,      // Stream word valid
    output logic                            in_ready_o,      // Stream word taken
    output logic [crtp_pkg::DATA_W-1:0]     mac_data_o,      // Beat data to MAC
    output logic [3:0]                      mac_nbytes_o,    // Valid bytes in beat
    output logic                            mac_sop_o,       // First beat of frame
    output logic                            mac_eop_o,       // Last beat of frame
    output logic [1:0]                      mac_port_o,      // Destination port
    output logic                            mac_append_crc_o,// MAC adds fresh CRC
    output logic                            mac_valid_o,     // Beat valid
    input  wire logic                       mac_ready_i,     // MAC takes beat
    input  wire logic [crtp_pkg::NPORT-1:0] link_up_i,       // Per-port link active
    input  wire logic                       strip_trailing_crc32_i, // Strip CRC
    input  wire logic                       crc_append_i,    // Hardware CRC append
    input  wire logic                       drop_errored_i,  // Drop rx-error records
    input  wire logic [crtp_pkg::NPORT-1:0] urun_clr_i,      // Clear underrun flags
    output logic [crtp_pkg::NPORT-1:0]      urun_o,          // Sticky underrun flags
    input  wire logic                       alloc_wr_i,      // Load memory split
    input  wire logic [31:0]                alloc_tx_i,      // New transmit share, bytes
    output logic [31:0]                     tx_alloc_o,      // Transmit stream bytes
    output logic [31:0]                     rx_alloc_o,      // Receive stream bytes
    output logic                            busy_o           // Record in flight
);

    crtp_pkg::crtp_regs_t q_r;
    crtp_pkg::crtp_regs_t q_nxt;

    always_comb begin
        crtp_pkg::crtp_hdr_t  h;
        crtp_pkg::crtp_beat_t pb;
        logic                 take;
        logic                 pop;
        logic                 push;
        logic [15:0]          olen;
        logic [15:0]          nb;
        logic [3:0]           urun_set;
        h        = crtp_pkg::crtp_hdr_t'(in_data_i);
        pb       = '0;
        take     = in_valid_i & q_r.in_ready;
        pop      = (q_r.cnt != 2'h0) & mac_ready_i;
        push     = 1'b0;
        olen     = 16'h0000;
        nb       = 16'h0000;
        urun_set = 4'h0;
        q_nxt    = q_r;
        case (q_r.st)
            crtp_pkg::S_HDR: begin
                if (take) begin
                    // Short frames under strip leave nothing to send
                    if (strip_trailing_crc32_i) begin
                        olen = (h.frame_len > crtp_pkg::CRC_BYTES) ?
                               h.frame_len - crtp_pkg::CRC_BYTES : 16'h0000;
                    end else begin
                        olen = h.frame_len;
                    end
                    q_nxt.port       = h.port;
                    q_nxt.words_left = h.rec_words;
                    q_nxt.bytes_left = olen;
                    q_nxt.drop       = (drop_errored_i & h.rx_err) | (olen == 16'h0000);
                    q_nxt.sop        = 1'b1;
                    q_nxt.append     = crc_append_i;
                    if (h.rec_words != 16'h0000) begin
                        q_nxt.st = crtp_pkg::S_LINK;
                    end
                end
            end
            crtp_pkg::S_LINK: begin
                // Waiting here blocks all ports: records stay in stream order
                if (link_up_i[q_r.port]) begin
                    q_nxt.st = crtp_pkg::S_BODY;
                end
            end
            crtp_pkg::S_BODY: begin
                if (take) begin
                    q_nxt.words_left = q_r.words_left - 16'h0001;
                    if (!q_r.drop && q_r.bytes_left != 16'h0000) begin
                        nb = (q_r.bytes_left >= crtp_pkg::WORD_BYTES) ?
                             crtp_pkg::WORD_BYTES : q_r.bytes_left;
                        push      = 1'b1;
                        pb.data   = in_data_i;
                        pb.nbytes = nb[3:0];
                        pb.sop    = q_r.sop;
                        pb.eop    = (q_r.bytes_left <= crtp_pkg::WORD_BYTES);
                        pb.port   = q_r.port;
                        pb.append = q_r.append;
                        q_nxt.bytes_left = q_r.bytes_left - nb;
                        q_nxt.sop        = 1'b0;
                    end
                    if (q_r.words_left == 16'h0001) begin
                        q_nxt.st = crtp_pkg::S_HDR;
                    end
                end else if (!q_r.drop && q_r.bytes_left != 16'h0000 && !q_r.sop &&
                             q_r.cnt == 2'h0) begin
                    urun_set[q_r.port] = 1'b1;
                end
            end
            default: begin
                q_nxt.st = crtp_pkg::S_HDR;
            end
        endcase
        // Two-entry buffer, head in e0; ordering kept FIFO
        case ({push, pop})
            2'b10: begin
                if (q_r.cnt == 2'h0) begin
                    q_nxt.e0 = pb;
                end else begin
                    q_nxt.e1 = pb;
                end
                q_nxt.cnt = q_r.cnt + 2'h1;
            end
            2'b01: begin
                q_nxt.e0  = q_r.e1;
                q_nxt.cnt = q_r.cnt - 2'h1;
            end
            2'b11: begin
                if (q_r.cnt == 2'h1) begin
                    q_nxt.e0 = pb;
                end else begin
                    q_nxt.e0 = q_r.e1;
                    q_nxt.e1 = pb;
                end
            end
            default: begin
                q_nxt.cnt = q_r.cnt;
            end
        endcase
        // Registered ready: promised only when the next word surely fits
        q_nxt.in_ready = (q_nxt.st == crtp_pkg::S_HDR) |
                         ((q_nxt.st == crtp_pkg::S_BODY) &
                          (q_nxt.drop | (q_nxt.bytes_left == 16'h0000) |
                           (q_nxt.cnt < crtp_pkg::BUF_DEPTH)));
        // Set wins over a clear in the same cycle
        q_nxt.urun = (q_r.urun & ~urun_clr_i) | urun_set;
        if (alloc_wr_i && !q_r.busy && alloc_tx_i <= crtp_pkg::TOTAL_MEM) begin
            q_nxt.tx_alloc = alloc_tx_i;
            q_nxt.rx_alloc = crtp_pkg::TOTAL_MEM - alloc_tx_i;
        end
        q_nxt.busy = (q_nxt.st != crtp_pkg::S_HDR) | (q_nxt.cnt != 2'h0);
        // Valid kept in its own flop so the MAC sees no decode glitch
        q_nxt.out_valid = (q_nxt.cnt != 2'h0);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_r          <= '0;
            q_r.tx_alloc <= crtp_pkg::TX_ALLOC_RST;
            q_r.rx_alloc <= crtp_pkg::TOTAL_MEM - crtp_pkg::TX_ALLOC_RST;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign in_ready_o       = q_r.in_ready;
    assign mac_data_o       = q_r.e0.data;
    assign mac_nbytes_o     = q_r.e0.nbytes;
    assign mac_sop_o        = q_r.e0.sop;
    assign mac_eop_o        = q_r.e0.eop;
    assign mac_port_o       = q_r.e0.port;
    assign mac_append_crc_o = q_r.e0.append;
    assign mac_valid_o      = q_r.out_valid;
    assign urun_o           = q_r.urun;
    assign tx_alloc_o       = q_r.tx_alloc;
    assign rx_alloc_o       = q_r.rx_alloc;
    assign busy_o           = q_r.busy;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_strip_len: assert property (
        q_r.st == crtp_pkg::S_HDR && in_valid_i && in_ready_o && strip_trailing_crc32_i &&
        in_data_i[15:0] > 16'h0004 |=> q_r.bytes_left == $past(in_data_i[15:0]) - 16'h0004)
        else $error("strip did not remove four CRC bytes");
    a_keep_len: assert property (
        q_r.st == crtp_pkg::S_HDR && in_valid_i && in_ready_o && !strip_trailing_crc32_i
        |=> q_r.bytes_left == $past(in_data_i[15:0]))
        else $error("frame length changed without strip");
    a_drop_err: assert property (
        q_r.st == crtp_pkg::S_BODY && q_r.drop |=> q_r.cnt <= $past(q_r.cnt))
        else $error("dropped record pushed a beat");
    a_port_hold: assert property (
        q_r.st == crtp_pkg::S_BODY && q_nxt.st == crtp_pkg::S_BODY |=> $stable(q_r.port))
        else $error("port changed inside a record");
    a_out_hold: assert property (
        mac_valid_o && !mac_ready_i |=> mac_valid_o && $stable(mac_data_o) &&
        $stable(mac_port_o))
        else $error("beat changed while stalled");
    a_urun_keep: assert property (
        urun_o[0] && !urun_clr_i[0] |=> urun_o[0])
        else $error("underrun flag lost without clear");
    a_alloc_sum: assert property (
        tx_alloc_o + rx_alloc_o == crtp_pkg::TOTAL_MEM)
        else $error("memory split does not add up");
    a_b2b_flow: assert property (
        q_r.st == crtp_pkg::S_BODY && q_r.cnt == 2'h1 && mac_ready_i && in_valid_i &&
        in_ready_o && q_r.words_left > 16'h0001 |=> in_ready_o)
        else $error("gap inserted in back-to-back flow");
    a_no_spont: assert property (
        q_r.st != crtp_pkg::S_BODY && !mac_valid_o |=> !mac_valid_o)
        else $error("beat emitted outside a record");
    a_alloc_busy: assert property (
        busy_o |=> $stable(tx_alloc_o))
        else $error("memory split changed while busy");

    c_strip_frame: cover property (mac_valid_o && mac_eop_o && strip_trailing_crc32_i);
    c_stall_full:  cover property (q_r.cnt == 2'h2 && !mac_ready_i);
    c_underrun:    cover property (|urun_o);
    c_drop_rec:    cover property (q_r.st == crtp_pkg::S_BODY && q_r.drop);

endmodule

/* File: tb/crtp_mac_model.sv */
// MAC-side sink model that records every beat it accepts
`timescale 1ns/1ps
module crtp_mac_model (
    input  wire logic                 clk_i,    // 250 MHz clock
    input  wire logic                 rst_n_i,  // Async reset, active low
    input  wire crtp_pkg::crtp_beat_t beat_i,   // Offered beat
    input  wire logic                 valid_i,  // Beat valid
    input  wire logic                 slow_i,   // Accept only every other cycle
    output logic                      ready_o   // Beat taken at edge
);
    crtp_pkg::crtp_beat_t got_q[$];
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ready_o <= 1'b0;
        end else begin
            // Slow mode stalls half the time so the skid buffer fills
            ready_o <= slow_i ? ~ready_o : 1'b1;
            if (valid_i && ready_o) begin
                got_q.push_back(beat_i);
            end
        end
    end
endmodule

/* File: tb/crtp_tb.sv */
// Self-checking bench of the record transmit path
`timescale 1ns/1ps
module tb;
    logic                 clk, rst_n, in_valid, in_ready, alloc_wr, strip, app, drop, slow;
    logic                 mvalid, mready, busy, sop, eop, appo;
    logic [63:0]          in_data, mdata;
    logic [3:0]           nbytes, urun, urun_clr, link;
    logic [1:0]           mport;
    logic [31:0]          alloc_tx, tx_alloc, rx_alloc;
    crtp_pkg::crtp_beat_t beat;
    crtp_pkg::crtp_beat_t exp_q[$];
    int                   failures, samples_checked;

    assign beat = {mdata, nbytes, sop, eop, mport, appo};

    crtp_tx_path uut (.clk_i(clk), .rst_n_i(rst_n), .in_data_i(in_data), .in_valid_i(in_valid),
        .in_ready_o(in_ready), .mac_data_o(mdata), .mac_nbytes_o(nbytes), .mac_sop_o(sop),
        .mac_eop_o(eop), .mac_port_o(mport), .mac_append_crc_o(appo), .mac_valid_o(mvalid),
        .mac_ready_i(mready), .link_up_i(link), .strip_trailing_crc32_i(strip),
        .crc_append_i(app), .drop_errored_i(drop), .urun_clr_i(urun_clr), .urun_o(urun),
        .alloc_wr_i(alloc_wr), .alloc_tx_i(alloc_tx), .tx_alloc_o(tx_alloc),
        .rx_alloc_o(rx_alloc), .busy_o(busy));

    crtp_mac_model mac (.clk_i(clk), .rst_n_i(rst_n), .beat_i(beat), .valid_i(mvalid),
        .slow_i(slow), .ready_o(mready));

    task chk(input logic [72:0] got, input logic [72:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function logic [63:0] wd(input int r, input int i);
        return {48'hC0DE_0000_0000, r[7:0], i[7:0]};
    endfunction

    // Holds valid high between words so back-to-back records stay gapless
    task put(input logic [63:0] w);
        in_data  <= w;
        in_valid <= 1'b1;
        do @(posedge clk); while (in_ready !== 1'b1);
    endtask

    task rec(input int r, input logic [1:0] p, input logic [15:0] flen,
             input logic [15:0] nw, input logic err, input logic sent, input int gap);
        int out;
        crtp_pkg::crtp_beat_t e;
        put({29'h0, err, p, nw, flen});
        for (int i = 0; i < nw; i++) begin
            put(wd(r, i));
            if (i == gap) begin
                in_valid <= 1'b0;
                repeat (6) @(posedge clk);
            end
        end
        out = strip ? flen - 4 : flen;
        for (int k = 0; sent && 8 * k < out; k++) begin
            e = '{wd(r, k), (out - 8 * k > 8) ? 4'h8 : 4'(out - 8 * k),
                  k == 0, out - 8 * k <= 8, p, app};
            exp_q.push_back(e);
        end
    endtask

    task done(input string name);
        logic [63:0] m;
        crtp_pkg::crtp_beat_t g;
        crtp_pkg::crtp_beat_t e;
        in_valid <= 1'b0;
        for (int n = 0; n < 300 && (busy !== 1'b0 || n < 4); n++) @(posedge clk);
        chk(73'(mac.got_q.size()), 73'(exp_q.size()));
        while (mac.got_q.size() > 0 && exp_q.size() > 0) begin
            g = mac.got_q.pop_front();
            e = exp_q.pop_front();
            m = ~64'h0 >> (64 - 8 * e.nbytes);
            g.data &= m;
            e.data &= m;
            chk(g, e);
        end
        mac.got_q.delete();
        exp_q.delete();
        $display("test %s done", name);
    endtask

    task alloc(input logic [31:0] v);
        alloc_tx <= v;
        alloc_wr <= 1'b1;
        @(posedge clk);
        alloc_wr <= 1'b0;
        @(posedge clk);
    endtask

    task results;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Whole run needs well under 5000 cycles
    initial begin
        #100000;
        failures++;
        results();
    end

    initial begin
        {rst_n, in_valid, alloc_wr, strip, app, drop, slow} = 7'h00;
        in_data  = 64'h0;
        urun_clr = 4'h0;
        link     = 4'hF;
        alloc_tx = 32'h0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk(tx_alloc, 32'h0100_0000);
        chk(rx_alloc, 32'h0F00_0000);
        chk({busy, urun}, 5'h00);
        for (int m = 0; m < 4; m++) begin
            {strip, app} <= m[1:0];
            slow         <= m[0];
            rec(m, 2'(m), 16'h0014, 16'h0003, 1'b0, 1'b1, -1);
            rec(m + 8, 2'(3 - m), 16'h000D, 16'h0002, 1'b0, 1'b1, -1);
            done("crc modes");
        end
        {strip, app} <= 2'h0;
        drop         <= 1'b1;
        rec(20, 2'h1, 16'h0014, 16'h0003, 1'b1, 1'b0, -1);
        rec(21, 2'h1, 16'h0014, 16'h0003, 1'b0, 1'b1, -1);
        done("drop on");
        drop <= 1'b0;
        rec(22, 2'h2, 16'h0014, 16'h0003, 1'b1, 1'b1, -1);
        done("drop off");
        strip <= 1'b1;
        link  <= 4'hB;
        rec(23, 2'h0, 16'h0004, 16'h0001, 1'b0, 1'b1, -1);
        fork
            rec(40, 2'h2, 16'h0014, 16'h0003, 1'b0, 1'b1, -1);
            begin
                repeat (10) @(posedge clk);
                chk({in_ready, mvalid, busy}, 3'b001);
                link <= 4'hF;
            end
        join
        done("short frame and link down");
        strip <= 1'b0;
        slow <= 1'b0;
        rec(30, 2'h2, 16'h0018, 16'h0003, 1'b0, 1'b1, 0);
        done("underrun");
        chk(urun, 4'h4);
        urun_clr <= 4'h4;
        @(posedge clk);
        urun_clr <= 4'h0;
        @(posedge clk);
        chk(urun, 4'h0);
        alloc(32'h0200_0000);
        chk({tx_alloc, rx_alloc}, {32'h0200_0000, 32'h0E00_0000});
        alloc(32'h1000_0001);
        chk({tx_alloc, rx_alloc}, {32'h0200_0000, 32'h0E00_0000});
        $display("test alloc done");
        results();
    end
endmodule
